// ==== rtl/ppo_defs.vh ====
// Purpose: Shared constants for the port pin override logic.
// Assumes: One port of eight pins behind an APB slave with 32-bit data.
// Notes:   Register offsets are byte addresses of aligned words.
`ifndef PPO_DEFS_VH
`define PPO_DEFS_VH

`define PPO_PINS            8
`define PPO_ADDR_W          12
`define PPO_DATA_W          32

`define PPO_OFF_PIN_INPUT   12'h000
`define PPO_OFF_DIRECTION   12'h004
`define PPO_OFF_LATCH       12'h008
`define PPO_OFF_PROC_CTRL   12'h00C
`define PPO_OFF_PIN_STATUS  12'h010
`define PPO_OFF_OVR_STATUS  12'h014

`define PPO_DIR_RST         8'h00
`define PPO_LATCH_RST       8'h00
`define PPO_PIN_RST         8'h00
`define PPO_CTRL_RST        1'b0
`define PPO_BYTE_ZERO       8'h00
`define PPO_WORD_ZERO       32'h00000000
`define PPO_PAD24           24'h000000
`define PPO_PAD31           31'h00000000

`define PPO_CTRL_PUOFF_BIT  0
`define PPO_ST_OE_LSB       0
`define PPO_ST_PU_LSB       8
`define PPO_ST_IE_LSB       16
`define PPO_ST_DRV_LSB      24

`endif

// ==== rtl/ppo_pin_mux.v ====
// Purpose: Merges register pin settings with per-pin peripheral overrides.
// Assumes: All inputs come from logic on the same clock as the registers.
// Notes:   Purely combinational; the caller registers every result.
`timescale 1ns/1ps
`default_nettype none
`include "ppo_defs.vh"

module ppo_pin_mux (
    input  wire [`PPO_PINS-1:0] dir_bits,
    input  wire [`PPO_PINS-1:0] latch_bits,
    input  wire                 global_pullup_off,
    input  wire                 sleep_req,
    input  wire [`PPO_PINS-1:0] ext_int_enable,
    input  wire [`PPO_PINS-1:0] pullup_override_enable,
    input  wire [`PPO_PINS-1:0] pullup_override_value,
    input  wire [`PPO_PINS-1:0] direction_override_enable,
    input  wire [`PPO_PINS-1:0] direction_override_value,
    input  wire [`PPO_PINS-1:0] drive_value_override_enable,
    input  wire [`PPO_PINS-1:0] drive_value_override_value,
    input  wire [`PPO_PINS-1:0] input_gate_override_enable,
    input  wire [`PPO_PINS-1:0] input_gate_override_value,
    output wire [`PPO_PINS-1:0] oe_nxt,
    output wire [`PPO_PINS-1:0] drive_nxt,
    output wire [`PPO_PINS-1:0] pullup_nxt,
    output wire [`PPO_PINS-1:0] input_en_nxt
);

    wire [`PPO_PINS-1:0] reg_pullup;
    wire [`PPO_PINS-1:0] sleep_clamp;

    // Pull-up from registers only for an input with its latch set.
    assign reg_pullup   = ~dir_bits & latch_bits & {`PPO_PINS{~global_pullup_off}};
    assign pullup_nxt   = (pullup_override_enable & pullup_override_value) |
                          (~pullup_override_enable & reg_pullup);

    assign oe_nxt       = (direction_override_enable & direction_override_value) |
                          (~direction_override_enable & dir_bits);

    assign drive_nxt    = (drive_value_override_enable & drive_value_override_value) |
                          (~drive_value_override_enable & latch_bits);

    // Sleep clamps every pin except those serving an enabled external interrupt.
    assign sleep_clamp  = {`PPO_PINS{sleep_req}} & ~ext_int_enable;
    assign input_en_nxt = (input_gate_override_enable & input_gate_override_value) |
                          (~input_gate_override_enable & ~sleep_clamp);

endmodule

`default_nettype wire

// ==== rtl/ppo_port.v ====
// Purpose: One eight-pin port with APB registers and peripheral override merge.
// Assumes: Overrides, sleep and interrupt enables come from logic on pclk.
// Notes:   Pin outputs are registered, so overrides reach the pad one cycle later, a latch toggle two cycles later.
//
// Contract
// - Sleep request clamps each pin's digital input to ground.
// - Pins with enabled external interrupt escape the sleep clamp.
// - Clamp release gives an edge that sets a disabled interrupt's flag.
// - Pull-ups stay off while reset is active.
// - Pull-up follows override, else on only for input, latch one, no global off.
// - Active pull-up override value alone decides the pull-up.
// - Driver enable follows direction override, else the direction bit.
// - Active direction override value alone decides the driver.
// - Driven level comes from drive override or else the output latch.
// - Active drive override ignores the output latch.
// - Latch-toggle override inverts the pin's output latch.
// - Input enable follows gate override, else the sleep state.
// - Active gate override value alone decides the input enable.
// - Alternate input taps the gated pad before the synchronizer.
// - Analog tap connects straight to the pad without gating.
// - Strobes shared per port, clock, sleep, pull-up off shared; overrides per pin.
// - Direction one is output; latch sets level or pull-up.
// - Writing one to the input register toggles the latch.
// - Pin passes a clock-high latch then a rising-edge register.
// - Global pull-up off disables every pull-up not under an active pull-up override.
`timescale 1ns/1ps
`default_nettype none
`include "ppo_defs.vh"

module ppo_port (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   clk_en,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`PPO_ADDR_W-1:0] paddr,
    input  wire [`PPO_DATA_W-1:0] pwdata,
    output reg  [`PPO_DATA_W-1:0] prdata,
    output reg                    pready,
    output reg                    pslverr,
    input  wire                   sleep_req,
    input  wire [`PPO_PINS-1:0]   ext_int_enable,
    input  wire [`PPO_PINS-1:0]   pullup_override_enable,
    input  wire [`PPO_PINS-1:0]   pullup_override_value,
    input  wire [`PPO_PINS-1:0]   direction_override_enable,
    input  wire [`PPO_PINS-1:0]   direction_override_value,
    input  wire [`PPO_PINS-1:0]   drive_value_override_enable,
    input  wire [`PPO_PINS-1:0]   drive_value_override_value,
    input  wire [`PPO_PINS-1:0]   latch_toggle_override,
    input  wire [`PPO_PINS-1:0]   input_gate_override_enable,
    input  wire [`PPO_PINS-1:0]   input_gate_override_value,
    input  wire [`PPO_PINS-1:0]   pad_in,
    output reg  [`PPO_PINS-1:0]   pad_out,
    output reg  [`PPO_PINS-1:0]   pad_oe,
    output reg  [`PPO_PINS-1:0]   pad_pullup_en,
    output reg  [`PPO_PINS-1:0]   input_enable,
    output wire [`PPO_PINS-1:0]   alt_func_input_tap,
    output wire [`PPO_PINS-1:0]   analog_pad_tap
);

    function addr_hit;
        input [`PPO_ADDR_W-1:0] addr;
        input [`PPO_ADDR_W-1:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    function [`PPO_DATA_W-1:0] byte_word;
        input [`PPO_PINS-1:0] value;
        begin
            byte_word = {`PPO_PAD24, value};
        end
    endfunction

    reg  [`PPO_PINS-1:0]   pin_direction_bit_r;
    reg  [`PPO_PINS-1:0]   pin_direction_bit_nxt;
    reg  [`PPO_PINS-1:0]   pin_output_latch_r;
    reg  [`PPO_PINS-1:0]   pin_output_latch_nxt;
    reg                    global_pullup_off_r;
    reg                    global_pullup_off_nxt;
    reg  [`PPO_PINS-1:0]   pin_sampled_input_r;
    reg  [`PPO_PINS-1:0]   sync_latch_r;
    reg  [`PPO_PINS-1:0]   toggle_mask;
    reg  [`PPO_DATA_W-1:0] rdata_nxt;
    reg                    rerr_nxt;

    wire [`PPO_PINS-1:0]   oe_nxt;
    wire [`PPO_PINS-1:0]   drive_nxt;
    wire [`PPO_PINS-1:0]   pullup_nxt;
    wire [`PPO_PINS-1:0]   input_en_nxt;
    wire [`PPO_PINS-1:0]   schmitt_out;
    wire [`PPO_PINS-1:0]   any_override;
    wire                   access_phase;
    wire                   commit;
    wire                   wr_commit;
    wire                   hit_pin;
    wire                   hit_dir;
    wire                   hit_latch;
    wire                   hit_ctrl;
    wire                   hit_pstat;
    wire                   hit_ostat;
    wire                   hit_any;

    // Address decode is common to all pins of the port.
    assign hit_pin      = addr_hit(paddr, `PPO_OFF_PIN_INPUT);
    assign hit_dir      = addr_hit(paddr, `PPO_OFF_DIRECTION);
    assign hit_latch    = addr_hit(paddr, `PPO_OFF_LATCH);
    assign hit_ctrl     = addr_hit(paddr, `PPO_OFF_PROC_CTRL);
    assign hit_pstat    = addr_hit(paddr, `PPO_OFF_PIN_STATUS);
    assign hit_ostat    = addr_hit(paddr, `PPO_OFF_OVR_STATUS);
    assign hit_any      = hit_pin | hit_dir | hit_latch | hit_ctrl | hit_pstat | hit_ostat;

    // The access phase waits one cycle, then completes when pready is high.
    assign access_phase = psel & penable;
    assign commit       = access_phase & pready;
    assign wr_commit    = commit & pwrite & hit_any;

    // Schmitt input is grounded whenever the digital input is disabled.
    assign schmitt_out        = pad_in & input_enable;
    assign alt_func_input_tap = schmitt_out;
    assign analog_pad_tap     = pad_in;

    assign any_override = pullup_override_enable | direction_override_enable |
                          drive_value_override_enable | input_gate_override_enable |
                          latch_toggle_override;

    ppo_pin_mux u_pin_mux (
        .dir_bits                    (pin_direction_bit_r),
        .latch_bits                  (pin_output_latch_r),
        .global_pullup_off           (global_pullup_off_r),
        .sleep_req                   (sleep_req),
        .ext_int_enable              (ext_int_enable),
        .pullup_override_enable      (pullup_override_enable),
        .pullup_override_value       (pullup_override_value),
        .direction_override_enable   (direction_override_enable),
        .direction_override_value    (direction_override_value),
        .drive_value_override_enable (drive_value_override_enable),
        .drive_value_override_value  (drive_value_override_value),
        .input_gate_override_enable  (input_gate_override_enable),
        .input_gate_override_value   (input_gate_override_value),
        .oe_nxt                      (oe_nxt),
        .drive_nxt                   (drive_nxt),
        .pullup_nxt                  (pullup_nxt),
        .input_en_nxt                (input_en_nxt)
    );

    // Write-one bits of the input register and peripheral toggles invert the latch.
    always @* begin
        toggle_mask = latch_toggle_override;
        if (wr_commit && hit_pin) begin
            toggle_mask = toggle_mask | pwdata[`PPO_PINS-1:0];
        end
    end

    always @* begin
        pin_direction_bit_nxt = pin_direction_bit_r;
        if (wr_commit && hit_dir) begin
            pin_direction_bit_nxt = pwdata[`PPO_PINS-1:0];
        end
    end

    always @* begin
        pin_output_latch_nxt = pin_output_latch_r;
        if (wr_commit && hit_latch) begin
            pin_output_latch_nxt = pwdata[`PPO_PINS-1:0];
        end
        pin_output_latch_nxt = pin_output_latch_nxt ^ toggle_mask;
    end

    always @* begin
        global_pullup_off_nxt = global_pullup_off_r;
        if (wr_commit && hit_ctrl) begin
            global_pullup_off_nxt = pwdata[`PPO_CTRL_PUOFF_BIT];
        end
    end

    // Read data is captured in the cycle that raises pready.
    always @* begin
        rdata_nxt = `PPO_WORD_ZERO;
        rerr_nxt  = 1'b0;
        if (!hit_any) begin
            rerr_nxt = 1'b1;
        end else if (pwrite) begin
            rdata_nxt = `PPO_WORD_ZERO;
        end else if (hit_pin) begin
            rdata_nxt = byte_word(pin_sampled_input_r);
        end else if (hit_dir) begin
            rdata_nxt = byte_word(pin_direction_bit_r);
        end else if (hit_latch) begin
            rdata_nxt = byte_word(pin_output_latch_r);
        end else if (hit_ctrl) begin
            rdata_nxt = {`PPO_PAD31, global_pullup_off_r};
        end else if (hit_pstat) begin
            rdata_nxt = {pad_out, input_enable, pad_pullup_en, pad_oe};
        end else begin
            rdata_nxt = byte_word(any_override);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PPO_WORD_ZERO;
        end else if (clk_en) begin
            if (commit) begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end else if (access_phase) begin
                pready  <= 1'b1;
                pslverr <= rerr_nxt;
                prdata  <= rdata_nxt;
            end
        end
    end

    // Port registers come up as tri-stated inputs with no pull-up.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction_bit_r <= `PPO_DIR_RST;
            pin_output_latch_r  <= `PPO_LATCH_RST;
            global_pullup_off_r <= `PPO_CTRL_RST;
        end else if (clk_en) begin
            pin_direction_bit_r <= pin_direction_bit_nxt;
            pin_output_latch_r  <= pin_output_latch_nxt;
            global_pullup_off_r <= global_pullup_off_nxt;
        end
    end

    // Pad controls are registered; reset forces driver and pull-up off at once.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_oe        <= `PPO_BYTE_ZERO;
            pad_out       <= `PPO_BYTE_ZERO;
            pad_pullup_en <= `PPO_BYTE_ZERO;
            input_enable  <= `PPO_BYTE_ZERO;
        end else if (clk_en) begin
            pad_oe        <= oe_nxt;
            pad_out       <= drive_nxt;
            pad_pullup_en <= pullup_nxt;
            input_enable  <= input_en_nxt;
        end
    end

    // Synchronizer front holds what a clock-high latch holds, captured as the clock falls.
    always @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_latch_r <= `PPO_PIN_RST;
        end else if (clk_en) begin
            sync_latch_r <= schmitt_out;
        end
    end

    // Synchronizer back: rising-edge register read by the input register.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sampled_input_r <= `PPO_PIN_RST;
        end else if (clk_en) begin
            pin_sampled_input_r <= sync_latch_r;
        end
    end

endmodule

`default_nettype wire

// ==== verification/ppo_periph_model.sv ====
// Purpose: Peripheral side that owns the per-pin override signals.
// Assumes: A load pulse presents a new override set one edge later.
// Notes:   The toggle request lasts exactly one cycle per load.
`timescale 1ns/1ps
`default_nettype none
module ppo_periph_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [63:0] ovr,
    input  wire logic [7:0]  tog,
    output var  logic [63:0] ovr_q = 64'h0000000000000000,
    output var  logic [7:0]  latch_toggle_override = 8'h00
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_q <= 64'h0000000000000000;
            latch_toggle_override <= 8'h00;
        end else begin
            if (load) begin
                ovr_q <= ovr;
            end
            latch_toggle_override <= load ? tog : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ==== verification/ppo_port_chk.sv ====
// Purpose: Assertions on the pin override port outputs.
// Assumes: Overrides, sleep and interrupt enables are sampled on pclk.
// Notes:   Bound to every ppo_port instance.
`timescale 1ns/1ps
`default_nettype none
module ppo_port_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       clk_en,
    input wire logic       sleep_req,
    input wire logic [7:0] ext_int_enable,
    input wire logic [7:0] pullup_override_enable,
    input wire logic [7:0] pullup_override_value,
    input wire logic [7:0] direction_override_enable,
    input wire logic [7:0] direction_override_value,
    input wire logic [7:0] drive_value_override_enable,
    input wire logic [7:0] drive_value_override_value,
    input wire logic [7:0] input_gate_override_enable,
    input wire logic [7:0] input_gate_override_value,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup_en,
    input wire logic [7:0] input_enable,
    input wire logic [7:0] alt_func_input_tap,
    input wire logic [7:0] analog_pad_tap
);
    // Attempts start only once reset is sampled released, so reset values are never judged.
    wire armed = presetn & clk_en;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pullup_ovr_a: assert property (armed |=> ((pad_pullup_en ^ $past(pullup_override_value))
        & $past(pullup_override_enable)) == 8'h00) else $error("pull-up override ignored");
    dir_ovr_a: assert property (armed |=> ((pad_oe ^ $past(direction_override_value))
        & $past(direction_override_enable)) == 8'h00) else $error("driver override ignored");
    drive_ovr_a: assert property (armed |=> ((pad_out ^ $past(drive_value_override_value))
        & $past(drive_value_override_enable) & pad_oe) == 8'h00) else $error("drive value wrong");
    gate_ovr_a: assert property (armed |=> ((input_enable ^ $past(input_gate_override_value))
        & $past(input_gate_override_enable)) == 8'h00) else $error("input gate override ignored");
    sleep_clamp_a: assert property (armed && sleep_req |=> (input_enable
        & ~$past(input_gate_override_enable | ext_int_enable)) == 8'h00) else $error("no clamp");
    int_escape_a: assert property (armed && sleep_req |=> (input_enable
        | ~$past(ext_int_enable & ~input_gate_override_enable)) == 8'hFF) else $error("int clamped");
    awake_input_a: assert property (armed && !sleep_req |=> (input_enable
        | $past(input_gate_override_enable)) == 8'hFF) else $error("input off while awake");
    alt_tap_a: assert property (alt_func_input_tap == (pad_in & input_enable))
        else $error("alternate input tap wrong");
    analog_tap_a: assert property (analog_pad_tap == pad_in)
        else $error("analog tap not the pad");
    cover property (sleep_req ##1 !sleep_req);
    cover property (direction_override_enable != 8'h00);
    cover property (sleep_req && ext_int_enable != 8'h00);
endmodule
bind ppo_port ppo_port_chk u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .sleep_req(sleep_req), .ext_int_enable(ext_int_enable),
    .pullup_override_enable(pullup_override_enable), .pullup_override_value(pullup_override_value),
    .direction_override_enable(direction_override_enable),
    .direction_override_value(direction_override_value),
    .drive_value_override_enable(drive_value_override_enable),
    .drive_value_override_value(drive_value_override_value),
    .input_gate_override_enable(input_gate_override_enable),
    .input_gate_override_value(input_gate_override_value), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .input_enable(input_enable),
    .alt_func_input_tap(alt_func_input_tap), .analog_pad_tap(analog_pad_tap));
`default_nettype wire

// ==== verification/ppo_port_tb_top.sv ====
// Purpose: Self-checking bench for the pin override port.
// Assumes: One APB transfer at a time; overrides come from the peripheral model.
// Notes:   Rows hold direction, latch, control, sleep, interrupt, overrides, status.
`timescale 1ns/1ps
`default_nettype none
module ppo_port_tb_top;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         clk_en = 1'b1;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h00000000;
    logic         sleep_req = 1'b0;
    logic [7:0]   eie = 8'h00;
    logic [7:0]   pad_in = 8'h00;
    logic         load = 1'b0;
    logic [63:0]  ovr = 64'h0000000000000000;
    logic [7:0]   tog = 8'h00;
    logic [63:0]  ovr_q;
    logic [7:0]   ltog, pad_out, pad_oe, pad_pu, ie, alt_tap, an_tap;
    logic [31:0]  prdata, rd, mask;
    logic         pready, pslverr, err;
    logic [135:0] r;
    int           miscompares = 0;
    int           n_checks = 0;
    int           cyc = 0;
    logic [135:0] rows [5] = '{
        136'hF0CC000000_0000000000000000_CCFF0CF0,
        136'hF0CC010000_0000000000000000_CCFF00F0,
        136'h000000010F_0000000000000000_000F0000,
        136'hF0CC010100_FFAAFF0FFF55F030_5530AA0F,
        136'h0FFF000000_0F00F00033000F00_CCF0F00F};
    ppo_periph_model i_model (.pclk(pclk), .presetn(presetn), .load(load), .ovr(ovr),
        .tog(tog), .ovr_q(ovr_q), .latch_toggle_override(ltog));
    ppo_port i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .ext_int_enable(eie),
        .pullup_override_enable(ovr_q[63:56]), .pullup_override_value(ovr_q[55:48]),
        .direction_override_enable(ovr_q[47:40]), .direction_override_value(ovr_q[39:32]),
        .drive_value_override_enable(ovr_q[31:24]), .drive_value_override_value(ovr_q[23:16]),
        .latch_toggle_override(ltog), .input_gate_override_enable(ovr_q[15:8]),
        .input_gate_override_value(ovr_q[7:0]), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pullup_en(pad_pu), .input_enable(ie),
        .alt_func_input_tap(alt_tap), .analog_pad_tap(an_tap));
    always #5 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ovr_load(input logic [63:0] v, input logic [7:0] t);
        @(posedge pclk);
        ovr <= v;
        tog <= t;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        chk({pad_oe, pad_pu, ie, 7'h00, pready}, 32'h00000000);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            apb(1'b1, 12'h004, r[135:128]);
            apb(1'b1, 12'h008, r[127:120]);
            apb(1'b1, 12'h00C, r[119:112]);
            sleep_req <= r[104];
            eie <= r[103:96];
            ovr_load(r[95:32], 8'h00);
            repeat (2) @(posedge pclk);
            apb(1'b0, 12'h010, 8'h00);
            mask = {r[7:0], 24'hFFFFFF};
            chk(rd & mask, r[31:0] & mask);
            apb(1'b0, 12'h004, 8'h00);
            chk(rd, {24'h000000, r[135:128]});
        end
        ovr_load(64'h0000000000000000, 8'h00);
        sleep_req <= 1'b0;
        apb(1'b1, 12'h008, 8'h0F);
        apb(1'b1, 12'h000, 8'h3C);
        apb(1'b0, 12'h008, 8'h00);
        chk(rd, 32'h00000033);
        ovr_load(64'h0000000000000000, 8'h81);
        apb(1'b0, 12'h008, 8'h00);
        chk(rd, 32'h000000B2);
        apb(1'b0, 12'h020, 8'h00);
        chk({err, rd[30:0]}, 32'h80000000);
        ovr_load(64'h0000000003000000, 8'h00);
        apb(1'b0, 12'h014, 8'h00);
        chk(rd, 32'h00000003);
        pad_in <= 8'hA5;
        repeat (2) @(posedge pclk);
        apb(1'b0, 12'h000, 8'h00);
        chk(rd, 32'h000000A5);
        chk({alt_tap, an_tap}, 32'h0000A5A5);
        sleep_req <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 chk(alt_tap, 32'h00000000);
        @(posedge pclk);
        sleep_req <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 chk(alt_tap, 32'h000000A5);
        apb(1'b1, 12'h004, 8'h00);
        apb(1'b1, 12'h008, 8'hFF);
        repeat (2) @(posedge pclk);
        #1 chk(pad_pu, 32'h000000FF);
        @(posedge pclk);
        clk_en <= 1'b0;
        ovr_load(64'hFF00000000000000, 8'h00);
        repeat (2) @(posedge pclk);
        #1 chk(pad_pu, 32'h000000FF);
        @(posedge pclk);
        clk_en <= 1'b1;
        @(posedge pclk);
        #1 chk(pad_pu, 32'h00000000);
        @(posedge pclk);
        presetn <= 1'b0;
        #1 chk({pad_oe, pad_pu}, 32'h00000000);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 8'h00);
        chk(rd, 32'h00000000);
        test_done();
    end
endmodule
`default_nettype wire
